// ---- verilog/fps_fan_pwm_source_select.sv ----
// Source arbitration, override, lock and polarity stage of the first fan output.
`timescale 1ns/100ps
module fps_fan_pwm_source_select #(
  parameter int RAMP_STEP_CYCLES = fps_pkg::FPS_RAMP_STEP_CYCLES,
  parameter int PWM_TICK_CYCLES = fps_pkg::FPS_PWM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port behind the serial management engine
  input wire fps_pkg::fps_reg_req_t regReq,
  output logic [7:0] regRdData,
  // Control sources
  input wire logic [fps_pkg::FPS_NUM_ZONES-1:0][3:0] zoneDuty,
  input wire logic [1:0] processorThrottleInputN,
  input wire logic [1:0] regulatorHotInputN,
  // Fan drive
  output logic firstFanOutput,
  output logic [3:0] appliedDuty
);
  import fps_pkg::*;

  // ----------------------------------------------------------------
  // Per-source requests
  // ----------------------------------------------------------------
  fps_state_t st;
  fps_state_t next_st;
  logic [FPS_NUM_RAMPS-1:0] rampActive;
  logic [FPS_NUM_ZONES-1:0][3:0] zoneReq;
  logic [FPS_NUM_RAMPS-1:0][3:0] rampReq;
  logic throttleEvent;
  logic [3:0] maxReq;
  logic rawPwm;

  assign rampActive = {~regulatorHotInputN, ~processorThrottleInputN};

  genvar g;
  generate
    for (g = 0; g < FPS_NUM_ZONES; g++)
    begin : gReq
      // An unbound source requests zero so it can never win the maximum.
      assign zoneReq[g] = st.binding[FPS_ZONE_LSB + g] ? zoneDuty[g] : FPS_DUTY_ZERO;
      assign rampReq[g] = st.binding[FPS_RAMP_LSB + g] ? st.ramp[g] : FPS_DUTY_ZERO;
    end
  endgenerate

  assign throttleEvent = |(rampActive[1:0] & st.binding[FPS_RAMP_LSB +: 2]);

  always_comb
  begin
    // The override is one more request, so a hotter source still wins over it.
    maxReq = st.manualDutyOverrideEn ? st.overrideDutyValue : FPS_DUTY_ZERO;
    for (int i = 0; i < FPS_NUM_ZONES; i++)
    begin
      if (zoneReq[i] > maxReq)
        maxReq = zoneReq[i];
      if (rampReq[i] > maxReq)
        maxReq = rampReq[i];
    end
    if (st.throttleLockFlag)
      maxReq = FPS_DUTY_FULL;
  end

  // Counter runs 0..14, so full duty is a constant level with no glitch.
  assign rawPwm = st.pwmCnt < st.curDuty;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.curDuty = maxReq;
    // Inverting only here keeps the polarity bit out of the arbitration.
    next_st.pwmOut = rawPwm ^ st.outputPolarityInvert;
    // ------------------------------------------------------------
    // Ramp steps and PWM counter
    // ------------------------------------------------------------
    // Ramps run while unbound, so binding a hot input mid-event starts at its level.
    if (st.rampDiv >= 32'(RAMP_STEP_CYCLES - 1))
    begin
      next_st.rampDiv = '0;
      for (int i = 0; i < FPS_NUM_RAMPS; i++)
      begin
        if (rampActive[i] && st.ramp[i] != FPS_DUTY_FULL)
          next_st.ramp[i] = st.ramp[i] + 4'h1;
        else if (!rampActive[i] && st.ramp[i] != FPS_DUTY_ZERO)
          next_st.ramp[i] = st.ramp[i] - 4'h1;
      end
    end
    else
      next_st.rampDiv = st.rampDiv + 32'h1;
    if (st.pwmDiv >= 32'(PWM_TICK_CYCLES - 1))
    begin
      next_st.pwmDiv = '0;
      next_st.pwmCnt = (st.pwmCnt == FPS_PWM_LAST) ? 4'h0 : st.pwmCnt + 4'h1;
    end
    else
      next_st.pwmDiv = st.pwmDiv + 32'h1;
    // ------------------------------------------------------------
    // Register writes and lock flag
    // ------------------------------------------------------------
    if (regReq.wrEn && regReq.addr == FPS_ADDR_BINDING)
      next_st.binding = regReq.wrData;
    if (regReq.wrEn && regReq.addr == FPS_ADDR_OVERRIDE)
    begin
      next_st.manualDutyOverrideEn = regReq.wrData[FPS_BIT_OVERRIDE_EN];
      next_st.outputPolarityInvert = regReq.wrData[FPS_BIT_INVERT];
      next_st.throttleLockEnable = regReq.wrData[FPS_BIT_LOCK_EN];
      next_st.overrideDutyValue = regReq.wrData[FPS_OVERRIDE_DUTY_LSB +: 4];
      // Writing a one to the flag does nothing, so software cannot fake a lock.
      if (!regReq.wrData[FPS_BIT_LOCK_FLAG])
        next_st.throttleLockFlag = 1'b0;
    end
    // A throttle event in the cycle of a clearing write keeps the flag set.
    if (st.throttleLockEnable && throttleEvent)
      next_st.throttleLockFlag = 1'b1;
    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Read data is registered and held, so a slow serial engine may pick it up late.
    if (regReq.rdEn)
    begin
      case (regReq.addr)
        FPS_ADDR_BINDING: next_st.rdData = st.binding;
        FPS_ADDR_OVERRIDE: next_st.rdData = {st.curDuty, st.throttleLockFlag, st.throttleLockEnable,
          st.outputPolarityInvert, st.manualDutyOverrideEn};
        default: next_st.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
      st.binding <= FPS_RST_BINDING;
      {st.throttleLockFlag, st.throttleLockEnable, st.outputPolarityInvert, st.manualDutyOverrideEn} <= FPS_RST_CTRL;
    end
    else
      st <= next_st;
  end

  assign regRdData = st.rdData;
  assign firstFanOutput = st.pwmOut;
  assign appliedDuty = st.curDuty;

  // ----------------------------------------------------------------
  // Assertions: requests and arbitration
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  zone_track_a: assert property (!$past(rst) && $past(st.binding[0]) |-> st.curDuty >= $past(zoneDuty[0]))
    else $error("Bound zone one not honoured.");
  ramp_step_a: assert property (st.rampDiv == 32'(RAMP_STEP_CYCLES - 1) && rampActive[0] && st.ramp[0] != 4'hF
    |=> st.ramp[0] == $past(st.ramp[0]) + 4'h1)
    else $error("Ramp did not step up.");
  ramp_fall_a: assert property (st.rampDiv == 32'(RAMP_STEP_CYCLES - 1) && !rampActive[0] && st.ramp[0] != 4'h0
    |=> st.ramp[0] == $past(st.ramp[0]) - 4'h1)
    else $error("Ramp did not step down.");
  max_wins_a: assert property (!$past(rst) && !$past(st.throttleLockFlag)
    |-> st.curDuty >= $past(zoneReq[0]) && st.curDuty >= $past(zoneReq[1]) && st.curDuty >= $past(zoneReq[2])
      && st.curDuty >= $past(zoneReq[3]) && st.curDuty >= $past(rampReq[0]) && st.curDuty >= $past(rampReq[1])
      && st.curDuty >= $past(rampReq[2]) && st.curDuty >= $past(rampReq[3]))
    else $error("Applied duty is below a bound request.");
  max_pick_a: assert property (!$past(rst) && !$past(st.throttleLockFlag) && !$past(st.manualDutyOverrideEn)
    |-> st.curDuty == 4'h0 || st.curDuty == $past(zoneReq[0]) || st.curDuty == $past(zoneReq[1])
      || st.curDuty == $past(zoneReq[2]) || st.curDuty == $past(zoneReq[3]) || st.curDuty == $past(rampReq[0])
      || st.curDuty == $past(rampReq[1]) || st.curDuty == $past(rampReq[2]) || st.curDuty == $past(rampReq[3]))
    else $error("Applied duty matches no bound request.");

  // ----------------------------------------------------------------
  // Assertions: registers, lock and polarity
  // ----------------------------------------------------------------
  override_floor_a: assert property (!$past(rst) && $past(st.manualDutyOverrideEn)
    |-> st.curDuty >= $past(st.overrideDutyValue))
    else $error("Override duty not applied.");
  override_write_a: assert property (regReq.wrEn && regReq.addr == FPS_ADDR_OVERRIDE
    |=> st.manualDutyOverrideEn == $past(regReq.wrData[FPS_BIT_OVERRIDE_EN]))
    else $error("Override enable did not take the write.");
  read_back_a: assert property (regReq.rdEn && regReq.addr == FPS_ADDR_OVERRIDE
    |=> regRdData[FPS_BIT_OVERRIDE_EN] == $past(st.manualDutyOverrideEn)
      && regRdData[FPS_BIT_INVERT] == $past(st.outputPolarityInvert))
    else $error("Control read-back does not match the control bits.");
  full_polarity_a: assert property (!$past(rst) && $past(st.curDuty) == 4'hF
    |-> firstFanOutput == !$past(st.outputPolarityInvert))
    else $error("Full duty level has wrong polarity.");
  zero_polarity_a: assert property (!$past(rst) && $past(st.curDuty) == 4'h0
    |-> firstFanOutput == $past(st.outputPolarityInvert))
    else $error("Zero duty level has wrong polarity.");
  bind_write_a: assert property (regReq.wrEn && regReq.addr == 8'hC8 |=> st.binding == $past(regReq.wrData))
    else $error("Binding register did not take the write.");
  lock_cause_a: assert property ($rose(st.throttleLockFlag)
    |-> $past(st.throttleLockEnable && throttleEvent))
    else $error("Lock set without a bound throttle event.");
  lock_full_a: assert property (st.throttleLockFlag |=> st.curDuty == 4'hF)
    else $error("Locked output not at full duty.");
  lock_hold_a: assert property (st.throttleLockFlag && !(regReq.wrEn && regReq.addr == FPS_ADDR_OVERRIDE
    && !regReq.wrData[FPS_BIT_LOCK_FLAG]) |=> st.throttleLockFlag)
    else $error("Lock flag dropped without a clearing write.");
  lock_clear_a: assert property (regReq.wrEn && regReq.addr == FPS_ADDR_OVERRIDE
    && !regReq.wrData[FPS_BIT_LOCK_FLAG] && !(st.throttleLockEnable && throttleEvent) |=> !st.throttleLockFlag)
    else $error("Clearing write left the lock flag set.");
  invert_last_a: assert property (!$past(rst)
    |-> firstFanOutput == ($past(rawPwm) ^ $past(st.outputPolarityInvert)))
    else $error("Inversion not applied to final waveform.");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  lock_seen_c: cover property (st.throttleLockEnable && throttleEvent ##1 st.throttleLockFlag);
  lock_clear_c: cover property (st.throttleLockFlag ##1 !st.throttleLockFlag);
  override_seen_c: cover property (st.manualDutyOverrideEn && st.curDuty == st.overrideDutyValue
    && st.overrideDutyValue != 4'h0);
  invert_full_c: cover property (st.outputPolarityInvert && st.curDuty == 4'hF ##1 !firstFanOutput);
  ramp_full_c: cover property (rampActive[0] && st.binding[FPS_RAMP_LSB] && st.ramp[0] == 4'hF);
endmodule

// ---- verilog/fps_pkg.sv ----
// Package with register map, field positions and state carriers for the fan PWM source selector.
package fps_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FPS_ADDR_BINDING = 8'hC8;
  localparam logic [7:0] FPS_ADDR_OVERRIDE = 8'hC9;
  localparam logic [7:0] FPS_RST_BINDING = 8'h00;
  localparam logic [3:0] FPS_RST_CTRL = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FPS_BIT_OVERRIDE_EN = 0;
  localparam int FPS_BIT_INVERT = 1;
  localparam int FPS_BIT_LOCK_EN = 2;
  localparam int FPS_BIT_LOCK_FLAG = 3;
  localparam int FPS_ZONE_LSB = 0;
  localparam int FPS_RAMP_LSB = 4;
  localparam int FPS_OVERRIDE_DUTY_LSB = 4;
  localparam int FPS_NUM_ZONES = 4;
  localparam int FPS_NUM_RAMPS = 4;

  // ----------------------------------------------------------------
  // Duty and timing constants
  // ----------------------------------------------------------------
  localparam logic [3:0] FPS_DUTY_FULL = 4'hF;
  localparam logic [3:0] FPS_DUTY_ZERO = 4'h0;
  localparam logic [3:0] FPS_PWM_LAST = 4'hE;
  localparam int FPS_CLK_HZ = 10000000;
  localparam int FPS_RAMP_STEP_US = 100000;
  localparam int FPS_RAMP_STEP_CYCLES = FPS_RAMP_STEP_US * (FPS_CLK_HZ / 1000000);
  localparam int FPS_PWM_TICK_CYCLES = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } fps_reg_req_t;

  typedef struct packed {
    logic [7:0] binding;
    logic throttleLockFlag;
    logic throttleLockEnable;
    logic outputPolarityInvert;
    logic manualDutyOverrideEn;
    logic [3:0] overrideDutyValue;
    logic [FPS_NUM_RAMPS-1:0][3:0] ramp;
    logic [31:0] rampDiv;
    logic [31:0] pwmDiv;
    logic [3:0] pwmCnt;
    logic [3:0] curDuty;
    logic [7:0] rdData;
    logic pwmOut;
  } fps_state_t;

endpackage

// ---- sim/fps_fan_model.sv ----
// Behavioural fan drive that counts high samples of the fan drive in windows of fifteen cycles.
`timescale 1ns/100ps
module fps_fan_model (
  // Clock and drive
  input wire logic clk,
  input wire logic fanIn,
  // Measurement
  output int highCount
);
  int acc = 0;
  int n = 0;
  // A window is not aligned to the PWM period, so only constant levels are judged.
  always @(posedge clk)
  begin
    acc = acc + int'(fanIn);
    n = n + 1;
    if (n == 15)
    begin
      highCount <= acc;
      acc = 0;
      n = 0;
    end
  end
endmodule

// ---- sim/fps_fan_pwm_source_select_test.sv ----
// Self-checking bench for the first fan output source selector.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module fps_fan_pwm_source_select_test;
  import fps_pkg::*;
  logic clk = 0;
  logic rst = 1;
  fps_reg_req_t regReq = '0;
  logic [7:0] regRdData;
  logic [3:0][3:0] zoneDuty = '0;
  logic [1:0] processorThrottleInputN = 2'b11;
  logic [1:0] regulatorHotInputN = 2'b11;
  logic firstFanOutput;
  logic [3:0] appliedDuty;
  logic [7:0] rv;
  int highCount;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  // A short ramp step keeps a full ramp near sixty cycles.
  fps_fan_pwm_source_select #(.RAMP_STEP_CYCLES(4), .PWM_TICK_CYCLES(1)) i_dut (.clk(clk), .rst(rst),
    .regReq(regReq), .regRdData(regRdData), .zoneDuty(zoneDuty), .processorThrottleInputN(processorThrottleInputN),
    .regulatorHotInputN(regulatorHotInputN), .firstFanOutput(firstFanOutput), .appliedDuty(appliedDuty));
  fps_fan_model i_fan (.clk(clk), .fanIn(firstFanOutput), .highCount(highCount));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq = {2'b10, a, d};
    @(negedge clk);
    regReq = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regReq = {2'b01, a, 8'h00};
    @(negedge clk);
    regReq = '0;
    @(negedge clk);
    rv = regRdData;
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    hold(10);
    rst = 0;
    rd(FPS_ADDR_BINDING);
    `CHK(rv, 8'h00)
    rd(FPS_ADDR_OVERRIDE);
    `CHK(rv, 8'h00)
    rd(8'hC7);
    `CHK(rv, 8'h00)
    zoneDuty = 16'h95B3;
    for (int i = 0; i < 4; i++)
    begin
      wr(FPS_ADDR_BINDING, 8'h01 << i);
      hold(3);
      `CHK(appliedDuty, zoneDuty[i])
    end
    wr(FPS_ADDR_BINDING, 8'h0F);
    hold(3);
    `CHK(appliedDuty, 4'hB)
    wr(FPS_ADDR_OVERRIDE, 8'hD1);
    hold(3);
    `CHK(appliedDuty, 4'hD)
    rd(FPS_ADDR_OVERRIDE);
    `CHK(rv, 8'hD1)
    wr(FPS_ADDR_OVERRIDE, 8'h41);
    hold(3);
    `CHK(appliedDuty, 4'hB)
    wr(FPS_ADDR_OVERRIDE, 8'hD0);
    hold(3);
    `CHK(appliedDuty, 4'hB)
    zoneDuty[0] = 4'hF;
    hold(35);
    `CHK(highCount, 15)
    wr(FPS_ADDR_OVERRIDE, 8'h02);
    hold(35);
    `CHK(highCount, 0)
    `CHK(appliedDuty, 4'hF)
    zoneDuty = '0;
    hold(35);
    `CHK(highCount, 15)
    wr(FPS_ADDR_OVERRIDE, 8'h00);
    for (int j = 0; j < 4; j++)
    begin
      wr(FPS_ADDR_BINDING, 8'h10 << j);
      {regulatorHotInputN, processorThrottleInputN} = ~(4'h1 << j);
      hold(12);
      `CHK(appliedDuty inside {[4'h1:4'h4]}, 1'b1)
      hold(58);
      `CHK(appliedDuty, 4'hF)
      {regulatorHotInputN, processorThrottleInputN} = 4'hF;
      hold(70);
      `CHK(appliedDuty, 4'h0)
    end
    wr(FPS_ADDR_OVERRIDE, 8'h04);
    wr(FPS_ADDR_BINDING, 8'h20);
    processorThrottleInputN = 2'b01;
    hold(3);
    `CHK(appliedDuty, 4'hF)
    rd(FPS_ADDR_OVERRIDE);
    `CHK(rv[3:0], 4'hC)
    processorThrottleInputN = 2'b11;
    hold(80);
    `CHK(appliedDuty, 4'hF)
    wr(FPS_ADDR_OVERRIDE, 8'h04);
    hold(3);
    `CHK(appliedDuty, 4'h0)
    rd(FPS_ADDR_OVERRIDE);
    `CHK(rv[3:0], 4'h4)
    wr(FPS_ADDR_OVERRIDE, 8'h08);
    rd(FPS_ADDR_OVERRIDE);
    `CHK(rv[3:0], 4'h0)
    results();
  end
endmodule
